// ### design/parity_calc.v
// ***********************************
// parity over the data bits below the character's top bit
// ***********************************
module parity_calc (
  // character
  input wire [8:0] dataWord,
  input wire nineBit,
  // polarity
  input wire oddSel,
  output wire parityBit
);

  wire [7:0] covered;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_cover
      // bit 7 is the parity slot itself in eight-bit frames
      if (i == 7)
      begin : g_top
        assign covered[i] = dataWord[i] & nineBit;
      end
      else
      begin : g_low
        assign covered[i] = dataWord[i];
      end
    end
  endgenerate

  assign parityBit = (^covered) ^ oddSel;

endmodule // parity_calc

// ### design/uart_ctrl_map.vh
`ifndef UART_CTRL_MAP_VH
`define UART_CTRL_MAP_VH

// ***********************************
// register byte addresses
// ***********************************
`define ADDR_FRAME 4'h0
`define ADDR_IRQEN 4'h4
`define ADDR_BRKCFG 4'h8
`define ADDR_STATUS 4'hc

// ***********************************
// frame register fields
// ***********************************
`define FR_LOOP 7
`define FR_HALT_WAIT 6
`define FR_RX_SRC 5
`define FR_NINE_BIT 4
`define FR_WAKE_ADDR 3
`define FR_QUIET_STOP 2
`define FR_PARITY_ON 1
`define FR_PARITY_ODD 0

// ***********************************
// irq enable register fields
// ***********************************
`define IE_TX_EMPTY 7
`define IE_TX_DONE 6
`define IE_RX_FULL 5
`define IE_QUIET 4
`define IE_TX_ON 3
`define IE_RX_ON 2
`define IE_STANDBY 1
`define IE_BREAK 0

// ***********************************
// break config and status fields
// ***********************************
`define BC_LONG_BREAK 0
`define ST_TX_BUSY 0
`define ST_RX_BUSY 1
`define ST_PREAMBLE 2
`define ST_LINE_QUIET 3

// ***********************************
// reset values and counts
// ***********************************
`define RST_CTRL 8'h00
`define BITS_SHORT 4'ha
`define BITS_LONG 4'hb
`define BREAK_EXTRA 4'h3
`define DATA_SHORT 4'h8
`define DATA_LONG 4'h9
`define PAD_TOP 22'h000000
`define PAD_STATUS 28'h0000000
`define PAD_BRK 31'h00000000

`endif

// ### design/uart_frame_ctrl.v
// Added by the designer: the register addresses and the APB slave port.
`include "uart_ctrl_map.vh"

module uart_frame_ctrl (
  // clock and reset
  input wire ref_clk,
  input wire arst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // timing and power
  input wire bitTick,
  input wire waitMode,
  output wire unitRun,
  // flags from the status logic
  input wire txEmptyFlag,
  input wire txDoneFlag,
  input wire rxFullFlag,
  input wire overrunFlag,
  input wire quietFlag,
  output reg irqRequest,
  // transmit data
  input wire txValid,
  input wire [8:0] txWord,
  output wire txReady,
  // receive data
  output reg rxDone,
  output reg [8:0] rxWord,
  output reg rxParityErr,
  output reg rxFrameErr,
  output reg quietDetect,
  // pins
  input wire rxPin,
  input wire txPinIn,
  output wire txPinOut,
  output wire txPinOe
);

  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;
  localparam RX_IDLE = 2'b00;
  localparam RX_DATA = 2'b01;
  localparam RX_STOP = 2'b10;

  reg [7:0] frameCtrl;
  reg [7:0] irqCtrl;
  reg longBreak;
  reg txState;
  reg txIsBreak;
  reg [13:0] txShift;
  reg [3:0] txCnt;
  reg preamblePending;
  reg breakQueued;
  reg [1:0] rxState;
  reg [3:0] rxCnt;
  reg [8:0] rxShift;
  reg [3:0] onesCnt;
  reg quietArmed;
  reg [2:0] rxSync;
  reg [2:0] txSync;
  reg rxLine;
  reg txLine;

  wire loopOn = frameCtrl[`FR_LOOP];
  wire nineBit = frameCtrl[`FR_NINE_BIT];
  wire parityOn = frameCtrl[`FR_PARITY_ON];
  wire parityOdd = frameCtrl[`FR_PARITY_ODD];
  wire txOn = irqCtrl[`IE_TX_ON];
  wire rxOn = irqCtrl[`IE_RX_ON];
  wire standby = irqCtrl[`IE_STANDBY];
  wire breakSend = irqCtrl[`IE_BREAK];
  wire breakWant = breakSend || breakQueued;
  wire [3:0] frameBits = nineBit ? `BITS_LONG : `BITS_SHORT;
  wire [3:0] dataBits = nineBit ? `DATA_LONG : `DATA_SHORT;
  wire [3:0] breakBits = longBreak ? frameBits + `BREAK_EXTRA : frameBits;

  // ***********************************
  // apb slave
  // ***********************************
  wire [3:0] regAddr = paddr[3:0];
  wire mapped = (paddr[31:4] == 28'h0000000) && (paddr[1:0] == 2'b00);
  wire wrStrobe = psel && penable && pwrite && mapped;
  wire wrFrame = wrStrobe && (regAddr == `ADDR_FRAME);
  wire wrIrq = wrStrobe && (regAddr == `ADDR_IRQEN);
  wire wrBrk = wrStrobe && (regAddr == `ADDR_BRKCFG);
  wire [3:0] statusBits;
  reg [31:0] readMux;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always @*
  begin
    readMux = 32'h00000000;
    if (mapped)
    begin
      case (regAddr)
        `ADDR_FRAME: readMux = {24'h000000, frameCtrl};
        `ADDR_IRQEN: readMux = {24'h000000, irqCtrl};
        `ADDR_BRKCFG: readMux = {`PAD_BRK, longBreak};
        `ADDR_STATUS: readMux = {`PAD_STATUS, statusBits};
        default: readMux = 32'h00000000;
      endcase
    end
  end

  // read data is latched in the setup phase so the access phase sees a flop
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= readMux;
  end

  // ***********************************
  // control registers
  // ***********************************
  wire wakeHit;
  wire txRise = wrIrq && pwdata[`IE_TX_ON] && !txOn;

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frameCtrl <= `RST_CTRL;
      irqCtrl <= `RST_CTRL;
      longBreak <= 1'b0;
    end
    else
    begin
      if (wrFrame)
        frameCtrl <= pwdata[7:0];
      if (wrBrk)
        longBreak <= pwdata[`BC_LONG_BREAK];
      // a software write in the same cycle as a wakeup takes priority
      if (wrIrq)
        irqCtrl <= pwdata[7:0];
      else if (wakeHit)
        irqCtrl[`IE_STANDBY] <= 1'b0;
    end
  end

  // ***********************************
  // wait mode gating
  // ***********************************
  assign unitRun = !(frameCtrl[`FR_HALT_WAIT] && waitMode);
  wire tick = bitTick && unitRun;

  // ***********************************
  // pin synchronisers
  // ***********************************
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxSync <= 3'b111;
      txSync <= 3'b111;
      rxLine <= 1'b1;
      txLine <= 1'b1;
    end
    else
    begin
      rxSync <= {rxSync[1:0], rxPin};
      txSync <= {txSync[1:0], txPinIn};
      // a level counts only once the second and third stages agree
      if (rxSync[1] == rxSync[2])
        rxLine <= rxSync[2];
      if (txSync[1] == txSync[2])
        txLine <= txSync[2];
    end
  end

  // ***********************************
  // transmitter
  // ***********************************
  wire txParity;
  wire txOut = (txState == TX_SEND) ? txShift[0] : 1'b1;
  wire txStartOk = txOn && tick && (txState == TX_IDLE);
  wire txMsb = parityOn ? txParity : (nineBit ? txWord[8] : txWord[7]);
  wire [10:0] txFrame = nineBit ? {1'b1, txMsb, txWord[7:0], 1'b0}
    : {2'b11, txMsb, txWord[6:0], 1'b0};

  parity_calc u_txParity (
    .dataWord(txWord),
    .nineBit(nineBit),
    .oddSel(parityOdd),
    .parityBit(txParity)
  );

  assign txReady = txStartOk && !breakWant && !preamblePending;
  assign txPinOut = txOut;
  assign txPinOe = txOn;

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      txState <= TX_IDLE;
      txIsBreak <= 1'b0;
      txShift <= 14'h3fff;
      txCnt <= 4'h0;
      preamblePending <= 1'b0;
      breakQueued <= 1'b0;
    end
    else if (!txOn && !txRise)
    begin
      txState <= TX_IDLE;
      txIsBreak <= 1'b0;
      preamblePending <= 1'b0;
      breakQueued <= 1'b0;
    end
    else
    begin
      if (txRise)
        preamblePending <= 1'b1;
      case (txState)
        TX_IDLE:
        begin
          if (txStartOk && breakWant)
          begin
            txState <= TX_SEND;
            txIsBreak <= 1'b1;
            breakQueued <= 1'b0;
            txShift <= 14'h0000;
            txCnt <= breakBits;
          end
          else if (txStartOk && preamblePending)
          begin
            txState <= TX_SEND;
            txIsBreak <= 1'b0;
            txShift <= 14'h3fff;
            txCnt <= frameBits;
            preamblePending <= 1'b0;
          end
          else if (txReady && txValid)
          begin
            txState <= TX_SEND;
            txIsBreak <= 1'b0;
            txShift <= {3'b111, txFrame};
            txCnt <= frameBits;
          end
        end
        TX_SEND:
        begin
          if (tick)
          begin
            txShift <= {1'b1, txShift[13:1]};
            txCnt <= txCnt - 4'h1;
            if (txCnt == 4'h1)
            begin
              if (txIsBreak && breakSend)
              begin
                txShift <= 14'h0000;
                txCnt <= breakBits;
              end
              else
              begin
                txState <= TX_IDLE;
                txIsBreak <= 1'b0;
              end
            end
          end
        end
        default: txState <= TX_IDLE;
      endcase
      // a toggle shorter than a bit time still owes one break
      if (wrIrq && pwdata[`IE_BREAK] && !breakSend)
        breakQueued <= 1'b1;
    end
  end

  // ***********************************
  // receiver input select
  // ***********************************
  // single-wire reads the transmit pin, so the far end must share it
  wire rxIn = !loopOn ? rxLine : (frameCtrl[`FR_RX_SRC] ? txLine : txOut);

  // ***********************************
  // receiver
  // ***********************************
  wire [8:0] rxCand = nineBit ? rxShift : {1'b0, rxShift[8:1]};
  wire rxMsb = nineBit ? rxCand[8] : rxCand[7];
  wire rxParity;
  wire stopTick = tick && (rxState == RX_STOP);
  wire addrWake = stopTick && standby && frameCtrl[`FR_WAKE_ADDR] && rxMsb;
  wire countOnes = rxIn && (!frameCtrl[`FR_QUIET_STOP] || rxState == RX_IDLE);
  wire [3:0] quietBits = nineBit ? `BITS_LONG : `BITS_SHORT;
  wire quietHit = tick && countOnes && (onesCnt == quietBits - 4'h1);
  wire lineWake = quietHit && standby && !frameCtrl[`FR_WAKE_ADDR];

  assign wakeHit = rxOn && (addrWake || lineWake);
  assign statusBits = {onesCnt >= quietBits, preamblePending, rxState != RX_IDLE,
    txState == TX_SEND};

  parity_calc u_rxParity (
    .dataWord(rxCand),
    .nineBit(nineBit),
    .oddSel(parityOdd),
    .parityBit(rxParity)
  );

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rxState <= RX_IDLE;
      rxCnt <= 4'h0;
      rxShift <= 9'h000;
      onesCnt <= 4'h0;
      quietArmed <= 1'b0;
      rxDone <= 1'b0;
      rxWord <= 9'h000;
      rxParityErr <= 1'b0;
      rxFrameErr <= 1'b0;
      quietDetect <= 1'b0;
    end
    else
    begin
      rxDone <= 1'b0;
      quietDetect <= 1'b0;
      if (!rxOn)
      begin
        rxState <= RX_IDLE;
        onesCnt <= 4'h0;
      end
      else if (tick)
      begin
        if (!rxIn || (frameCtrl[`FR_QUIET_STOP] && rxState != RX_IDLE))
          onesCnt <= 4'h0;
        else if (countOnes && onesCnt < quietBits)
          onesCnt <= onesCnt + 4'h1;
        // a frame must complete before another quiet report
        if (quietHit && quietArmed && !standby)
        begin
          quietDetect <= 1'b1;
          quietArmed <= 1'b0;
        end
        case (rxState)
          RX_IDLE:
          begin
            if (!rxIn)
            begin
              rxState <= RX_DATA;
              rxCnt <= 4'h0;
            end
          end
          RX_DATA:
          begin
            rxShift <= {rxIn, rxShift[8:1]};
            rxCnt <= rxCnt + 4'h1;
            if (rxCnt == dataBits - 4'h1)
              rxState <= RX_STOP;
          end
          RX_STOP:
          begin
            rxState <= RX_IDLE;
            // standby hides characters except the one that wakes the unit
            if (!standby || addrWake)
            begin
              rxDone <= 1'b1;
              rxWord <= rxCand;
              rxParityErr <= parityOn && (rxMsb != rxParity);
              rxFrameErr <= !rxIn;
              quietArmed <= 1'b1;
            end
          end
          default: rxState <= RX_IDLE;
        endcase
      end
    end
  end

  // ***********************************
  // interrupt request
  // ***********************************
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      irqRequest <= 1'b0;
    else
      irqRequest <= (irqCtrl[`IE_TX_EMPTY] && txEmptyFlag)
        || (irqCtrl[`IE_TX_DONE] && txDoneFlag)
        || (!standby && irqCtrl[`IE_RX_FULL] && (rxFullFlag || overrunFlag))
        || (!standby && irqCtrl[`IE_QUIET] && quietFlag);
  end

endmodule // uart_frame_ctrl

// ### testbench/serial_peer.sv
// ****
// remote serial node
// ****
module serial_peer (
  // clock and bit timing
  input logic ref_clk,
  input logic bitTick,
  // lines
  input logic lineIn,
  output logic rxLine
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv = 1'h1;
  logic tickD = 1'h0;
  logic busy = 1'h0;
  logic [3:0] cnt = 4'h0;
  logic [8:0] sh = 9'h000;
  logic [8:0] frame = 9'h000;
  int zeros = 0;
  assign rxLine = drv;
  // sample a cycle after the tick, once the pin has moved
  always @(posedge ref_clk)
  begin
    tickD <= bitTick;
    if (tickD && !lineIn)
      zeros <= zeros + 1;
    if (tickD && busy)
    begin
      sh <= {lineIn, sh[8:1]};
      cnt <= cnt + 4'h1;
      busy <= (cnt != 4'h8);
      if (cnt == 4'h8)
        frame <= {lineIn, sh[8:1]};
    end
    else if (tickD && !lineIn)
    begin
      busy <= 1'h1;
      cnt <= 4'h0;
    end
  end
  task automatic send(input logic [9:0] f);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge ref_clk iff bitTick);
      drv <= f[i];
    end
  endtask
endmodule // serial_peer

// ### testbench/uart_frame_and_irq_control_tb_top.sv
module uart_frame_and_irq_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'h0;
  logic arst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic bitTick = 1'h0;
  logic waitMode = 1'h0;
  logic [4:0] flg = 5'h00;
  logic txValid = 1'h0;
  logic [8:0] txWord = 9'h000;
  logic [2:0] tc = 3'h0;
  logic [31:0] q;
  logic serr;
  int err_total = 0;
  int comparisons = 0;
  wire pready, pslverr, unitRun, irqRequest, txReady, rxDone, rxParityErr, quietDetect;
  wire txPinOut, txPinOe, rxPin, rxFrameErr;
  wire [31:0] prdata;
  wire [8:0] rxWord;
  // released transmit wire is pulled up
  wire txWire = txPinOe ? txPinOut : 1'h1;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    tc <= tc + 3'h1;
    bitTick <= (tc == 3'h7);
  end
  uart_frame_ctrl u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .bitTick(bitTick), .waitMode(waitMode), .unitRun(unitRun),
    .txEmptyFlag(flg[4]), .txDoneFlag(flg[3]), .rxFullFlag(flg[2]), .overrunFlag(flg[1]),
    .quietFlag(flg[0]), .irqRequest(irqRequest), .txValid(txValid), .txWord(txWord),
    .txReady(txReady), .rxDone(rxDone), .rxWord(rxWord), .rxParityErr(rxParityErr),
    .rxFrameErr(rxFrameErr), .quietDetect(quietDetect), .rxPin(rxPin), .txPinIn(txWire),
    .txPinOut(txPinOut), .txPinOe(txPinOe));
  serial_peer u_peer (.ref_clk(ref_clk), .bitTick(bitTick), .lineIn(txWire), .rxLine(rxPin));
  // ****
  // helpers
  // ****
  task automatic stop_test;
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bail(input logic bad);
    if (bad)
    begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    bail(pready !== 1'h1);
    q = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic waitRx;
    int n;
    n = 0;
    while (rxDone !== 1'h1 && n < 400)
    begin
      @(negedge ref_clk);
      n++;
    end
    bail(rxDone !== 1'h1);
  endtask
  task automatic irqAt(input logic v);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("irq", irqRequest, v);
    @(posedge ref_clk);
  endtask
  // offer one character and wait until the transmitter takes it
  task automatic txPut(input logic [8:0] w, output int n);
    n = 0;
    txWord <= w;
    txValid <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (txReady !== 1'h1 && n < 300);
    bail(txReady !== 1'h1);
    txValid <= 1'h0;
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_reset;
    for (int a = 0; a < 12; a += 4)
    begin
      apb(a, 1'h0, 32'h0);
      chk("reset value", q, 32'h0);
    end
    apb(32'h0, 1'h1, 32'hffffffff);
    apb(32'h0, 1'h0, 32'h0);
    chk("frame rw", q, 32'hff);
    apb(32'h0, 1'h1, 32'h0);
    apb(32'h10, 1'h0, 32'h0);
    chk("unmapped err", serr, 1'h1);
    chk("unmapped data", q, 32'h0);
    chk("oe reset", txPinOe, 1'h0);
  endtask
  task automatic test_loop(input logic odd, input logic [8:0] exp, input int minWait);
    int n;
    apb(32'h0, 1'h1, {24'h0, 8'h82} | odd);
    u_peer.drv <= 1'h0;
    txPut(9'h035, n);
    chk("preamble gap", n > minWait, 1'h1);
    waitRx();
    chk("loop word", rxWord, exp);
    chk("loop parity err", rxParityErr, 1'h0);
    repeat (16) @(posedge ref_clk);
    chk("wire frame", u_peer.frame, {1'h1, exp[7:0]});
    u_peer.drv <= 1'h1;
  endtask
  task automatic test_break(input logic lng, input logic held);
    int bits;
    bits = lng ? 13 : 10;
    apb(32'h8, 1'h1, {31'h0, lng});
    repeat (128) @(posedge ref_clk);
    u_peer.zeros <= 0;
    apb(32'h4, 1'h1, 32'h09);
    repeat (8 * (held ? bits + 3 : 0)) @(posedge ref_clk);
    apb(32'h4, 1'h1, 32'h08);
    repeat (320) @(posedge ref_clk);
    chk("break zeros", u_peer.zeros, held ? 2 * bits : bits);
  endtask
  task automatic test_irq;
    logic [2:0] en [5] = '{3'h7, 3'h6, 3'h5, 3'h5, 3'h4};
    @(posedge ref_clk);
    for (int i = 0; i < 5; i++)
    begin
      flg <= 5'h10 >> i;
      apb(32'h4, 1'h1, 32'h0);
      irqAt(1'h0);
      apb(32'h4, 1'h1, 32'h1 << en[i]);
      irqAt(1'h1);
    end
    flg <= 5'h04;
    apb(32'h4, 1'h1, 32'h22);
    irqAt(1'h0);
    flg <= 5'h00;
  endtask
  task automatic test_wait;
    apb(32'h0, 1'h1, 32'h40);
    waitMode <= 1'h1;
    @(negedge ref_clk);
    chk("halted", unitRun, 1'h0);
    apb(32'h0, 1'h1, 32'h0);
    @(negedge ref_clk);
    chk("runs in wait", unitRun, 1'h1);
    @(posedge ref_clk);
    waitMode <= 1'h0;
  endtask
  task automatic test_wake;
    apb(32'h0, 1'h1, 32'h08);
    apb(32'h4, 1'h1, 32'h06);
    u_peer.send(10'h34a);
    waitRx();
    chk("address char", rxWord, 9'h0a5);
    apb(32'h4, 1'h0, 32'h0);
    chk("standby cleared", q, 32'h04);
    // stop bit sent as zero
    u_peer.send(10'h1fe);
    waitRx();
    chk("frame err", rxFrameErr, 1'h1);
    @(posedge ref_clk);
    u_peer.drv <= 1'h1;
  endtask
  // all-ones character: the quiet count starts after the start or the stop bit
  task automatic test_quiet(input logic quiet_count_from_stop, input int gap);
    int n;
    apb(32'h0, 1'h1, {29'h0, quiet_count_from_stop, 2'h0});
    u_peer.send(10'h3fe);
    waitRx();
    chk("quiet char", rxWord, 9'h0ff);
    n = 0;
    while (quietDetect !== 1'h1 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    bail(quietDetect !== 1'h1);
    chk("quiet gap", n, gap);
  endtask
  // single-wire, nine-bit: the receiver listens on the transmit wire
  task automatic test_single;
    int n;
    apb(32'h0, 1'h1, 32'hb0);
    apb(32'h4, 1'h1, 32'h0c);
    u_peer.drv <= 1'h0;
    txPut(9'h1c3, n);
    chk("long preamble", n > 88, 1'h1);
    waitRx();
    chk("single word", rxWord, 9'h1c3);
    chk("single frame err", rxFrameErr, 1'h0);
    @(posedge ref_clk);
    u_peer.drv <= 1'h1;
    apb(32'h4, 1'h1, 32'h0);
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'h1;
    test_reset();
    apb(32'h4, 1'h1, 32'h0c);
    test_loop(1'h0, 9'h035, 70);
    test_loop(1'h1, 9'h0b5, 0);
    apb(32'h0, 1'h1, 32'h0);
    for (int c = 0; c < 4; c++)
      test_break(c[1], c[0]);
    apb(32'h4, 1'h1, 32'h0);
    @(negedge ref_clk);
    chk("oe off", txPinOe, 1'h0);
    test_irq();
    test_wait();
    test_wake();
    test_quiet(1'h0, 8);
    test_quiet(1'h1, 80);
    test_single();
    stop_test();
  end
endmodule // uart_frame_and_irq_control_tb_top

// ### testbench/uart_frame_ctrl_sva.sv
// ****
// port checks
// ****
module uart_frame_ctrl_sva (
  // clock and reset
  input logic ref_clk,
  input logic arst_n,
  // apb
  input logic psel,
  input logic penable,
  input logic [31:0] paddr,
  input logic pready,
  input logic pslverr,
  // timing and flags
  input logic bitTick,
  input logic waitMode,
  input logic unitRun,
  input logic txEmptyFlag,
  input logic txDoneFlag,
  input logic rxFullFlag,
  input logic overrunFlag,
  input logic quietFlag,
  input logic irqRequest,
  // serial
  input logic txReady,
  input logic rxDone,
  input logic quietDetect,
  input logic txPinOut,
  input logic txPinOe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && paddr[31:4] != 28'h0 |-> pslverr)
    else $error("no slave error");
  a_err_access: assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
  a_run_wait: assert property (!waitMode |-> unitRun) else $error("unit halted");
  a_irq_cause: assert property (irqRequest |->
    $past(txEmptyFlag || txDoneFlag || rxFullFlag || overrunFlag || quietFlag))
    else $error("irq without flag");
  a_ready_tick: assert property (txReady |-> bitTick && unitRun && txPinOe)
    else $error("ready off tick");
  a_rx_pulse: assert property (rxDone |=> !rxDone) else $error("rxDone long");
  a_quiet_pulse: assert property (quietDetect |=> !quietDetect)
    else $error("quiet long");
  a_pin_tick: assert property (txPinOe && $past(txPinOe) && $changed(txPinOut) |->
    $past(bitTick && unitRun)) else $error("pin moved off tick");
  c_rx: cover property (rxDone);
  c_quiet: cover property (quietDetect);
  c_take: cover property (txReady);
endmodule // uart_frame_ctrl_sva

bind uart_frame_ctrl uart_frame_ctrl_sva u_sva (.ref_clk(ref_clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .bitTick(bitTick), .waitMode(waitMode), .unitRun(unitRun), .txEmptyFlag(txEmptyFlag),
  .txDoneFlag(txDoneFlag), .rxFullFlag(rxFullFlag), .overrunFlag(overrunFlag),
  .quietFlag(quietFlag), .irqRequest(irqRequest), .txReady(txReady), .rxDone(rxDone),
  .quietDetect(quietDetect), .txPinOut(txPinOut), .txPinOe(txPinOe));
